// ==== logic/swtsq_pkg.sv ====
/*
 * Shared constants and types of the sweep trigger sequencer: register
 * offsets, reset values, mode and source codes, carrier structs.
 * Assumes a 32-bit classic Wishbone bus with byte addresses.
 */
`default_nettype none

package swtsq_pkg;

   // ******************************************************************
   // Register map (byte offsets)
   // ******************************************************************
   localparam logic [7:0] ADR_CTRL  = 8'h00;
   localparam logic [7:0] ADR_MODE  = 8'h04;
   localparam logic [7:0] ADR_COUNT = 8'h08;
   localparam logic [7:0] ADR_CMD   = 8'h0C;
   localparam logic [7:0] ADR_NPTS  = 8'h10;
   localparam logic [7:0] ADR_STAT  = 8'h14;

   // ******************************************************************
   // Field positions and limits
   // ******************************************************************
   localparam int unsigned CMD_TRIG_BIT = 0;
   localparam int unsigned CNT_W        = 10;
   localparam logic [9:0]  CNT_MIN      = 10'h001;
   localparam logic [9:0]  CNT_MAX      = 10'h3E7;
   localparam logic [9:0]  CNT_RST      = 10'h001;
   localparam logic [9:0]  NPTS_RST     = 10'h0C9;

   // ******************************************************************
   // Codes
   // ******************************************************************
   typedef enum logic [1:0] {
      SRC_AUTO = 2'b00,
      SRC_EXT  = 2'b01,
      SRC_BUS  = 2'b10,
      SRC_KEY  = 2'b11
   } swtsq_src_type;

   typedef enum logic [1:0] {
      MODE_HOLD   = 2'b00,
      MODE_SINGLE = 2'b01,
      MODE_COUNT  = 2'b10,
      MODE_CONT   = 2'b11
   } swtsq_mode_type;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_ARMED = 2'b01,
      ST_PWAIT = 2'b10,
      ST_MEAS  = 2'b11
   } swtsq_state_type;

   // ******************************************************************
   // Carriers
   // ******************************************************************
   typedef struct packed {
      swtsq_src_type src;
      logic          on_point;
      logic          edge_neg;
   } swtsq_ctrl_type;

   localparam swtsq_ctrl_type CTRL_RST =
      '{src: SRC_AUTO, on_point: 1'b0, edge_neg: 1'b0};

   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [7:0]  adr;
      logic [3:0]  sel;
      logic [31:0] dat;
   } swtsq_wb_req_type;

endpackage : swtsq_pkg

`default_nettype wire

// ==== logic/swtsq_top.sv ====
/*
 * Sweep trigger sequencer: picks a trigger source, edge-detects the
 * external trigger, and paces a measurement engine point by point
 * through hold, single, counted and continuous sweep modes.
 * Assumes a classic Wishbone master and an engine that answers each
 * meas_start_o with one meas_done_i pulse; inputs are synchronous.
 */
// Contract
// (RULE_01) In sweep event mode one accepted trigger runs a whole sweep.
// (RULE_02) In point event mode each trigger measures one point only.
// (RULE_03) Autotrigger runs the mode's sweeps whatever the event mode.
// (RULE_04) Positive polarity triggers on the rising external edge.
// (RULE_05) Negative polarity triggers on the falling external edge.
// (RULE_06) Modes are hold, single, counted repeat and continuous.
// (RULE_07) After the counted sweeps it holds and ignores triggers.
// (RULE_08) Single mode runs one sweep on a trigger, then holds.
// (RULE_09) With autotrigger, selecting single starts a sweep at once.
// (RULE_10) With autotrigger, entering a count starts sweeping at once.
// (RULE_11) The repeat count accepts only 1 through 999.
// (RULE_12) A repeat count of 1 behaves exactly like single mode.
// (RULE_13) Continuous mode repeats sweeps until a hold command.
// (RULE_14) Hold stops sweeping at once and later triggers are ignored.
// (RULE_15) Source is autotrigger, external, bus command or manual key.
// (RULE_16) The done count clears on a new mode or a count write.

`timescale 1ns/100ps
`default_nettype none

module swtsq_top #(
   parameter int unsigned PNT_W = 10
) (
   // Clock and reset
   input  wire  logic                       core_clk_i,
   input  wire  logic                       resetn_i,
   // Wishbone slave
   input  wire  swtsq_pkg::swtsq_wb_req_type wb_req_i,
   output logic [31:0]                      wb_dat_o,
   output logic                             wb_ack_o,
   // Trigger inputs
   input  wire  logic                       ext_trig_i,
   input  wire  logic                       key_trig_i,
   // Measurement engine
   output logic                             meas_start_o,
   output logic                             meas_abort_o,
   output logic [PNT_W-1:0]                 meas_point_o,
   input  wire  logic                       meas_done_i,
   // Status
   output logic                             sweep_end_o,
   output logic                             hold_o
);
   import swtsq_pkg::*;

   // ******************************************************************
   // Declarations
   // ******************************************************************
   swtsq_ctrl_type       ctrl_r;
   swtsq_mode_type       mode_r;
   swtsq_mode_type       mode_nxt;
   swtsq_state_type      state_r;
   logic [CNT_W-1:0]     count_r;
   logic [CNT_W-1:0]     done_cnt_r;
   logic [PNT_W-1:0]     npts_r;
   logic [PNT_W-1:0]     point_r;
   logic [PNT_W-1:0]     last_pt;
   logic                 ack_r;
   logic [31:0]          rdat_r;
   logic                 ext_q_r;
   logic                 start_r;
   logic                 abort_r;
   logic                 end_r;
   logic                 acc;
   logic                 wr;
   logic                 wr_mode;
   logic                 wr_cnt;
   logic                 cnt_ok;
   logic                 new_sel;
   logic                 ext_hit;
   logic                 trig;
   logic                 auto;
   logic                 wait_pt;
   logic                 sweep_last;
   logic                 group_last;

   // ******************************************************************
   // Bus decode
   // ******************************************************************
   // One access per request; ack follows one cycle later
   assign acc     = wb_req_i.cyc & wb_req_i.stb & ~ack_r;
   // Writes land at the edge where the master samples ack
   assign wr      = wb_req_i.cyc & wb_req_i.stb & ack_r &
                    wb_req_i.we & wb_req_i.sel[0];
   assign wr_mode = wr & (wb_req_i.adr == ADR_MODE);
   assign wr_cnt  = wr & (wb_req_i.adr == ADR_COUNT);
   assign cnt_ok  = (wb_req_i.dat[9:0] >= CNT_MIN) &&
                    (wb_req_i.dat[9:0] <= CNT_MAX);       // [RULE_11]
   assign new_sel = wr_mode | (wr_cnt & cnt_ok);

   // Ack generation
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= acc;
      end
   end

   // Read data capture; unmapped offsets read zero
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         rdat_r <= 32'h00000000;
      end else if (acc) begin
         unique case (wb_req_i.adr)
            ADR_CTRL:  rdat_r <= {28'h0, ctrl_r};
            ADR_MODE:  rdat_r <= {30'h0, mode_r};
            ADR_COUNT: rdat_r <= {22'h0, count_r};
            ADR_NPTS:  rdat_r <= {{(32-PNT_W){1'b0}}, npts_r};
            ADR_STAT:  rdat_r <= {6'h00, done_cnt_r, 10'(point_r),
                                  4'h0, state_r};
            default:   rdat_r <= 32'h00000000;
         endcase
      end
   end

   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdat_r;

   // ******************************************************************
   // Configuration registers
   // ******************************************************************
   // Source, event and polarity
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ctrl_r <= CTRL_RST;
      end else if (wr && wb_req_i.adr == ADR_CTRL) begin
         ctrl_r <= swtsq_ctrl_type'(wb_req_i.dat[3:0]);  // [RULE_15]
      end
   end

   // Repeat count, out of range writes dropped
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         count_r <= CNT_RST;
      end else if (wr_cnt && cnt_ok) begin
         count_r <= wb_req_i.dat[9:0];                  // [RULE_11]
      end
   end

   // Points per sweep, zero refused
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         npts_r <= NPTS_RST[PNT_W-1:0];
      end else if (wr && wb_req_i.adr == ADR_NPTS &&
                   wb_req_i.dat[PNT_W-1:0] != '0) begin
         npts_r <= wb_req_i.dat[PNT_W-1:0];
      end
   end

   // ******************************************************************
   // Trigger selection
   // ******************************************************************
   // External input history for edge detection
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         ext_q_r <= 1'b0;
      end else begin
         ext_q_r <= ext_trig_i;
      end
   end

   assign ext_hit = ctrl_r.edge_neg ?
                    (ext_q_r & ~ext_trig_i) :              // [RULE_05]
                    (~ext_q_r & ext_trig_i);               // [RULE_04]
   assign auto    = (ctrl_r.src == SRC_AUTO);

   // Source multiplexer
   always_comb begin
      unique case (ctrl_r.src)
         SRC_AUTO: trig = 1'b1;                          // [RULE_03]
         SRC_EXT:  trig = ext_hit;
         SRC_BUS:  trig = wb_req_i.adr == ADR_CMD &&
                          wr && wb_req_i.dat[CMD_TRIG_BIT];
         SRC_KEY:  trig = key_trig_i;                    // [RULE_15]
      endcase
   end

   // Each point waits for a trigger only off autotrigger
   assign wait_pt = ctrl_r.on_point & ~auto;             // [RULE_02]

   // ******************************************************************
   // Sweep bookkeeping
   // ******************************************************************
   assign last_pt    = npts_r - {{(PNT_W-1){1'b0}}, 1'b1};
   assign sweep_last = (state_r == ST_MEAS) & meas_done_i &
                       (point_r == last_pt);
   assign group_last = sweep_last &
                       ((mode_r == MODE_SINGLE) |          // [RULE_08]
                        ((mode_r == MODE_COUNT) &&         // [RULE_12]
                         (done_cnt_r + 10'h001 == count_r))); // [RULE_07]

   // Mode select; a count entry selects counted mode
   always_comb begin
      mode_nxt = mode_r;
      if (wr_mode) begin
         mode_nxt = swtsq_mode_type'(wb_req_i.dat[1:0]); // [RULE_06]
      end else if (wr_cnt && cnt_ok) begin
         mode_nxt = MODE_COUNT;                          // [RULE_10]
      end else if (group_last) begin
         mode_nxt = MODE_HOLD;                           // [RULE_07]
      end
   end

   // Mode register
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         mode_r <= MODE_HOLD;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // Completed sweeps
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         done_cnt_r <= 10'h000;
      end else if (new_sel) begin
         done_cnt_r <= 10'h000;                          // [RULE_16]
      end else if (sweep_last) begin
         done_cnt_r <= done_cnt_r + 10'h001;
      end
   end

   // ******************************************************************
   // Sequencer
   // ******************************************************************
   // State, point index and engine strobes
   always_ff @(posedge core_clk_i) begin
      if (!resetn_i) begin
         state_r <= ST_IDLE;
         point_r <= '0;
         start_r <= 1'b0;
         abort_r <= 1'b0;
         end_r   <= 1'b0;
      end else begin
         start_r <= 1'b0;
         abort_r <= 1'b0;
         end_r   <= sweep_last;
         if (new_sel) begin
            abort_r <= (state_r == ST_MEAS);             // [RULE_14]
            point_r <= '0;
            state_r <= (mode_nxt == MODE_HOLD) ? ST_IDLE :
                       ST_ARMED;                         // [RULE_09]
         end else begin
            unique case (state_r)
               ST_IDLE: begin
                  state_r <= ST_IDLE;                    // [RULE_14]
               end
               ST_ARMED, ST_PWAIT: begin
                  if (trig) begin
                     state_r <= ST_MEAS;
                     start_r <= 1'b1;
                  end
               end
               ST_MEAS: begin
                  if (meas_done_i && group_last) begin
                     state_r <= ST_IDLE;                 // [RULE_07]
                     point_r <= '0;
                  end else if (meas_done_i) begin
                     point_r <= sweep_last ? '0 :        // [RULE_13]
                                point_r + {{(PNT_W-1){1'b0}}, 1'b1};
                     if (wait_pt) begin
                        state_r <= ST_PWAIT;             // [RULE_02]
                     end else begin
                        start_r <= 1'b1;                 // [RULE_01]
                     end
                  end
               end
            endcase
         end
      end
   end

   assign meas_start_o = start_r;
   assign meas_abort_o = abort_r;
   assign meas_point_o = point_r;
   assign sweep_end_o  = end_r;
   assign hold_o       = (mode_r == MODE_HOLD);

   // ******************************************************************
   // Assertions
   // ******************************************************************
   default clocking cb @(posedge core_clk_i);
   endclocking
   default disable iff (!resetn_i);

   sequence s_auto_sel;
      new_sel && mode_nxt != MODE_HOLD && auto;
   endsequence

   sequence s_armed_then_start;
      state_r == ST_ARMED ##1 meas_start_o && point_r == '0;
   endsequence

   a_hold_stops_at_once: assert property (                 // [RULE_14]
      wr_mode && wb_req_i.dat[1:0] == MODE_HOLD |=>
         state_r == ST_IDLE && hold_o ##1 !meas_start_o)
      else $error("hold did not stop sweeping");

   a_auto_starts_now: assert property (                    // [RULE_09]
      s_auto_sel |=> s_armed_then_start)
      else $error("autotrigger did not start sweep");

   a_idle_ignores_trig: assert property (                  // [RULE_07]
      state_r == ST_IDLE && !new_sel |=> !meas_start_o)
      else $error("trigger accepted while held");

   a_rise_edge_trig: assert property (                     // [RULE_04]
      state_r == ST_ARMED && ctrl_r.src == SRC_EXT && !new_sel &&
      !ctrl_r.edge_neg && !$past(ext_trig_i) && ext_trig_i
      |=> meas_start_o)
      else $error("rising edge not taken");

   a_fall_edge_trig: assert property (                     // [RULE_05]
      state_r == ST_ARMED && ctrl_r.src == SRC_EXT && !new_sel &&
      ctrl_r.edge_neg && $past(ext_trig_i) && !ext_trig_i
      |=> meas_start_o)
      else $error("falling edge not taken");

   a_single_then_hold: assert property (                   // [RULE_08]
      sweep_last && mode_r == MODE_SINGLE && !new_sel
      |=> hold_o && state_r == ST_IDLE)
      else $error("single sweep did not hold");

   a_count_then_hold: assert property (                    // [RULE_07]
      sweep_last && mode_r == MODE_COUNT && !new_sel &&
      done_cnt_r + 10'h001 == count_r |=> hold_o [*2])
      else $error("counted sweeps did not hold");

   a_count_range_kept: assert property (                   // [RULE_11]
      count_r >= CNT_MIN && count_r <= CNT_MAX)
      else $error("repeat count out of range");

   a_done_cleared: assert property (                       // [RULE_16]
      new_sel |=> done_cnt_r == 10'h000)
      else $error("done count not cleared");

   a_point_waits: assert property (                        // [RULE_02]
      state_r == ST_MEAS && meas_done_i && wait_pt && !new_sel &&
      !group_last |=> state_r == ST_PWAIT && !meas_start_o)
      else $error("point event did not wait");

   a_cont_repeats: assert property (                       // [RULE_13]
      sweep_last && mode_r == MODE_CONT && !new_sel && !wait_pt
      |=> meas_start_o && point_r == '0 && !hold_o)
      else $error("continuous sweep did not repeat");

endmodule : swtsq_top

`default_nettype wire

// ==== test/swtsq_eng_model.sv ====
/*
 * Behavioural measurement engine that stands behind the sequencer.
 * Assumes one clock; the bench picks the per-point latency (1 to 4).
 */
`timescale 1ns/100ps
`default_nettype none

module swtsq_eng_model (
   // Clock and reset
   input  wire logic       core_clk_i,
   input  wire logic       resetn_i,
   // Sequencer side
   input  wire logic       meas_start_i,
   input  wire logic       meas_abort_i,
   input  wire logic [2:0] lat_i,
   output logic            meas_done_o
);
   // ******************************************************************
   // Point timer
   // ******************************************************************
   logic [2:0] cnt_r;

   // One done pulse lat_i cycles after a start; abort drops it
   always_ff @(posedge core_clk_i) begin
      meas_done_o <= 1'b0;
      if (!resetn_i || meas_abort_i) begin
         cnt_r <= 3'h0;
      end else if (meas_start_i) begin
         cnt_r <= lat_i;
      end else if (cnt_r != 3'h0) begin
         cnt_r       <= cnt_r - 3'h1;
         meas_done_o <= (cnt_r == 3'h1);
      end
   end
endmodule : swtsq_eng_model

`default_nettype wire

// ==== test/tb_top.sv ====
/*
 * Self-checking bench of the sweep trigger sequencer: Wishbone
 * register traffic, trigger sources and a measurement engine model.
 * Assumes the package constants and the registered one-cycle ack.
 */
`timescale 1ns/100ps
`default_nettype none

module tb_top;
   import swtsq_pkg::*;
   localparam int NP = 3;
   logic             core_clk_i, resetn_i, ext_trig_i, key_trig_i;
   swtsq_wb_req_type wb_req;
   logic [31:0]      wb_dat, rd;
   logic             wb_ack, m_start, m_abort, m_done, s_end, hold;
   logic [9:0]       m_point, last_pt;
   logic [2:0]       lat;
   int               err_count, n_tests, n_st, n_end, cyc_cnt, n_ab;
   int               seed, n, i, s0, e0;

   // ******************************************************************
   // Design and engine
   // ******************************************************************
   swtsq_top swtsq_top_inst (
      .core_clk_i  (core_clk_i), .resetn_i    (resetn_i),
      .wb_req_i    (wb_req),     .wb_dat_o    (wb_dat),
      .wb_ack_o    (wb_ack),     .ext_trig_i  (ext_trig_i),
      .key_trig_i  (key_trig_i), .meas_start_o(m_start),
      .meas_abort_o(m_abort),    .meas_point_o(m_point),
      .meas_done_i (m_done),     .sweep_end_o (s_end),
      .hold_o      (hold));
   swtsq_eng_model swtsq_eng_model_inst (
      .core_clk_i  (core_clk_i), .resetn_i    (resetn_i),
      .meas_start_i(m_start),    .meas_abort_i(m_abort),
      .lat_i       (lat),        .meas_done_o (m_done));

   // Clock of 100 ns period
   initial begin
      core_clk_i = 1'b0;
      forever #50 core_clk_i = ~core_clk_i;
   end

   // ******************************************************************
   // Tasks
   // ******************************************************************
   task automatic conclude;
      $display("errors=%0d compares=%0d", err_count, n_tests);
      if (err_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : conclude

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("mismatch t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task automatic wb(input logic we, input logic [7:0] adr,
                     input logic [31:0] d);
      int t;
      @(posedge core_clk_i);
      wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF,
                  dat: d};
      t = 0;
      do begin
         @(posedge core_clk_i);
         t++;
      end while (wb_ack !== 1'b1 && t < 100);
      if (wb_ack !== 1'b1) begin
         err_count++;
         $display("mismatch t=%0t bus ack missing", $time);
      end
      rd = wb_dat;
      wb_req <= '0;
      // Let the edge's register updates settle before the caller looks
      @(negedge core_clk_i);
   endtask : wb

   task automatic cycles(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask : cycles

   task automatic wait_hold;
      int t;
      t = 0;
      while (hold !== 1'b1 && t < 3000) begin
         @(posedge core_clk_i);
         t++;
      end
      if (hold !== 1'b1) begin
         err_count++;
         $display("mismatch t=%0t hold never reached", $time);
      end
   endtask : wait_hold

   // Snapshot counters off the edge, pick a new engine latency
   task automatic mark;
      @(negedge core_clk_i);
      s0 = n_st;
      e0 = n_end;
      lat = 3'((($random(seed)) & 3) + 1);
   endtask : mark

   task automatic expect_cnt(input int ds, input int de);
      @(negedge core_clk_i);
      chk(n_st - s0, ds);
      chk(n_end - e0, de);
   endtask : expect_cnt

   task automatic drv(input logic ext, input logic key);
      @(posedge core_clk_i);
      ext_trig_i <= ext;
      key_trig_i <= key;
   endtask : drv

   // Count starts and sweep ends, cut a hang short
   always @(posedge core_clk_i) begin
      cyc_cnt++;
      if (m_start === 1'b1) begin
         n_st++;
         last_pt = m_point;
      end
      if (s_end === 1'b1) n_end++;
      if (m_abort === 1'b1) n_ab++;
      if (cyc_cnt > 20000) begin
         err_count++;
         conclude();
      end
   end

   // ******************************************************************
   // Main sequence
   // ******************************************************************
   initial begin
      seed = 32'h6CDC;
      {err_count, n_tests, n_st, n_end, cyc_cnt, n_ab} = '0;
      resetn_i = 1'b0;
      ext_trig_i = 1'b0;
      key_trig_i = 1'b0;
      wb_req = '0;
      lat = 3'h1;
      repeat (4) @(posedge core_clk_i);
      resetn_i <= 1'b1;
      wb(1'b0, ADR_COUNT, 32'h0); chk(rd, 32'h1);
      wb(1'b0, ADR_NPTS, 32'h0); chk(rd, 32'(NPTS_RST));
      wb(1'b0, 8'h18, 32'h0); chk(rd, 32'h0);
      wb(1'b1, ADR_NPTS, 32'(NP));
      // Auto source, single sweep then hold
      mark(); wb(1'b1, ADR_MODE, 32'h1); wait_hold();
      expect_cnt(NP, 1);
      wb(1'b0, ADR_STAT, 32'h0); chk(32'(rd[25:16]), 32'h1);
      cycles(20); expect_cnt(NP, 1);
      // Auto source, counted sweeps, count 1 first
      for (i = 0; i < 2; i++) begin
         n = (i == 0) ? 1 : 2 + (($random(seed)) & 3);
         mark(); wb(1'b1, ADR_COUNT, 32'(n)); wait_hold();
         expect_cnt(NP * n, n);
         wb(1'b0, ADR_STAT, 32'h0); chk(32'(rd[25:16]), 32'(n));
      end
      // Count range edges, external source idle
      // CTRL: [3:2] source, [1] point event, [0] falling edge
      wb(1'b1, ADR_CTRL, 32'h4);
      wb(1'b1, ADR_COUNT, 32'h3E7);
      wb(1'b1, ADR_COUNT, 32'h3E8);
      wb(1'b1, ADR_COUNT, 32'h0);
      wb(1'b0, ADR_COUNT, 32'h0); chk(rd, 32'h3E7);
      wb(1'b1, ADR_MODE, 32'h0); chk(32'(hold), 32'h1);
      // External rising edge
      mark(); wb(1'b1, ADR_MODE, 32'h1); cycles(10);
      expect_cnt(0, 0);
      drv(1'b1, 1'b0); wait_hold(); expect_cnt(NP, 1);
      drv(1'b0, 1'b0); cycles(3); drv(1'b1, 1'b0); cycles(20);
      expect_cnt(NP, 1);
      // External falling edge
      wb(1'b1, ADR_CTRL, 32'h5); drv(1'b0, 1'b0);
      mark(); wb(1'b1, ADR_MODE, 32'h1); drv(1'b1, 1'b0); cycles(10);
      expect_cnt(0, 0);
      drv(1'b0, 1'b0); wait_hold(); expect_cnt(NP, 1);
      // Key source, one point per trigger
      wb(1'b1, ADR_CTRL, 32'hE);
      mark(); wb(1'b1, ADR_MODE, 32'h1);
      for (i = 0; i < NP; i++) begin
         cycles(8);
         chk(n_st - s0, i);
         drv(1'b0, 1'b1); drv(1'b0, 1'b0); cycles(8);
         chk(32'(last_pt), 32'(i));
      end
      expect_cnt(NP, 1);
      // Bus command trigger
      wb(1'b1, ADR_CTRL, 32'h8);
      mark(); wb(1'b1, ADR_MODE, 32'h1); wb(1'b1, ADR_CMD, 32'h1);
      wait_hold(); expect_cnt(NP, 1);
      // Auto source ignores point event
      wb(1'b1, ADR_CTRL, 32'h2);
      mark(); wb(1'b1, ADR_MODE, 32'h1); wait_hold();
      expect_cnt(NP, 1);
      // Continuous until hold
      wb(1'b1, ADR_CTRL, 32'h0);
      mark(); wb(1'b1, ADR_MODE, 32'h3); cycles(100);
      chk(32'(n_end - e0 >= 3), 32'h1);
      chk(32'(hold), 32'h0);
      i = n_ab;
      wb(1'b1, ADR_MODE, 32'h0);
      mark(); cycles(30); expect_cnt(0, 0);
      chk(32'(n_ab - i), 32'h1);
      chk(32'(hold), 32'h1);
      conclude();
   end
endmodule : tb_top

`default_nettype wire
